// ---- design/ife_extractor.sv ----
// Behaviour
// - Branch target relative unless absolute bit set
// - 32-bit mode extends offsets to 32 bits
// - Conditional offset bits 16-29, shifted, sign-extended
// - Bits 11-15 select tested condition bit
// - Branch option field from bits 6-10
// - Condition logic sources from 11-15, 16-20
// - Destination condition bit index bits 6-10
// - Field selectors: destination 6-8, source 11-13
// - Condition field mask bits 12-19 enable fields
// - Load/store displacement bits 16-31 sign-extended
// - 64-bit word offset 16-29, shifted, extended
// - FP status mask bits 7-14 enable fields
// - FP register specifiers from fixed positions
// - 64-bit mode compare width from bit 10
// - Long offset bits 6-29, shifted, sign-extended
// - Save return address when bit 31 set
// - Rotate mask ones begin+32 to stop+32
// - Bit 21 enables overflow and summary update
// - Integer record sets bits 0-3
// - FP record copies four status flags
// - 32-bit mode segment index bits 12-15
// - Special register selector from bits 11-20
`timescale 1ns/100ps
`default_nettype none
module ife_extractor (
	input  wire logic                        clk,
	input  wire logic                        resetn,
	input  wire logic                        in_valid,
	input  wire logic [ife_pkg::INSN_W-1:0]  instr_word,
	input  wire logic [ife_pkg::DATA_W-1:0]  instr_addr,
	input  wire logic                        mode_64bit,
	input  wire logic                        is_branch,
	input  wire logic                        use_long_offset,
	input  wire logic                        is_ext_arith,
	input  wire logic                        is_int_record_op,
	input  wire logic                        is_fp_record_op,
	input  wire logic                        is_cond_mask_move,
	input  wire logic                        is_fp_mask_move,
	input  wire logic                        is_compare,
	input  wire logic [ife_pkg::DATA_W-1:0]  int_result,
	input  wire logic                        ov_detect,
	input  wire logic                        so_current,
	input  wire logic                        fp_exc_summary,
	input  wire logic                        fp_enabled_summary,
	input  wire logic                        fp_invalid,
	input  wire logic                        fp_overflow,
	output logic                             out_valid,
	output logic [4:0]                       cond_test_index,
	output logic [4:0]                       branch_option_field,
	output logic [4:0]                       cond_src_first,
	output logic [4:0]                       cond_src_second,
	output logic [4:0]                       cond_dest_index,
	output logic [2:0]                       cond_field_dest,
	output logic [2:0]                       cond_field_src,
	output logic [31:0]                      cond_field_we,
	output logic [31:0]                      fp_field_we,
	output logic [4:0]                       fp_src_first,
	output logic [4:0]                       fp_src_second,
	output logic [4:0]                       fp_src_third,
	output logic [4:0]                       fp_dest_index,
	output logic [ife_pkg::DATA_W-1:0]       branch_target,
	output logic [ife_pkg::DATA_W-1:0]       return_addr,
	output logic                             return_addr_we,
	output logic [ife_pkg::DATA_W-1:0]       ls_disp,
	output logic [ife_pkg::DATA_W-1:0]       word_disp,
	output logic                             word_disp_valid,
	output logic                             cmp_is_64,
	output logic [ife_pkg::DATA_W-1:0]       rot_mask,
	output logic                             ov_we,
	output logic                             ov_value,
	output logic                             so_value,
	output logic                             cr_int_we,
	output logic [3:0]                       cr_int_bits,
	output logic                             cr_fp_we,
	output logic [3:0]                       cr_fp_bits,
	output logic [3:0]                       seg_reg_select,
	output logic                             seg_valid,
	output logic [9:0]                       spr_select
);
	import ife_pkg::*;

	ife_mask_if mif ();

	ife_out_s    out_ff;
	ife_out_s    nxt_out;
	logic        valid_ff;
	logic        nxt_valid;

	logic [31:0] f_cond_off;
	logic [31:0] f_long_off;
	logic [31:0] f_ls;
	logic [31:0] f_word;
	logic [31:0] f_cfmask;
	logic [31:0] f_fpmask;
	logic [31:0] f_spr_lo;
	logic [31:0] f_spr_hi;
	logic [31:0] f_begin;
	logic [31:0] f_stop;
	logic [63:0] disp;
	logic [63:0] base;
	logic [63:0] res;
	logic        so_after;
	logic        lt;
	logic        eq;

	assign f_begin = ife_field(instr_word, MASK_BEGIN_FIRST, MASK_BEGIN_LAST);
	assign f_stop  = ife_field(instr_word, MASK_STOP_FIRST, MASK_STOP_LAST);
	assign mif.mask_begin = f_begin[4:0];
	assign mif.mask_stop  = f_stop[4:0];

	ife_rot_mask u_rot (
		.m (mif.gen)
	);

	always_comb begin
		nxt_valid = in_valid;
		nxt_out   = out_ff;
		f_cond_off = ife_field(instr_word, COND_OFF_FIRST, COND_OFF_LAST);
		f_long_off = ife_field(instr_word, LONG_OFF_FIRST, LONG_OFF_LAST);
		f_ls       = ife_field(instr_word, LS_DISP_FIRST, LS_DISP_LAST);
		f_word     = ife_field(instr_word, WORD_OFF_FIRST, WORD_OFF_LAST);
		f_cfmask   = ife_field(instr_word, CFMASK_FIRST, CFMASK_LAST);
		f_fpmask   = ife_field(instr_word, FPMASK_FIRST, FPMASK_LAST);
		f_spr_lo   = ife_field(instr_word, SPR_LOW_FIRST, SPR_LOW_LAST);
		f_spr_hi   = ife_field(instr_word, SPR_HIGH_FIRST, SPR_HIGH_LAST);

		// Branch displacement choice
		if (use_long_offset) begin
			disp = ife_sext({38'h0, f_long_off[23:0], 2'h0},
				LONG_OFF_W + OFF_PAD_W);
		end else begin
			disp = ife_sext({48'h0, f_cond_off[13:0], 2'h0},
				COND_OFF_W + OFF_PAD_W);
		end
		base = instr_word[31 - ABS_TARGET_POS] ? 64'h0 : instr_addr;

		// Integer result as signed quantity at machine width
		res = mode_64bit ? int_result :
			ife_sext({32'h0, int_result[31:0]}, HALF_W);
		lt  = res[63];
		eq  = (res == 64'h0);
		so_after = so_current;
		if (is_ext_arith && instr_word[31 - OV_ENABLE_POS]) begin
			so_after = so_current | ov_detect;
		end

		if (in_valid) begin
			nxt_out.cond_test_index = 5'(ife_field(instr_word,
				COND_TEST_FIRST, COND_TEST_LAST));
			nxt_out.branch_option_field = 5'(ife_field(instr_word,
				BR_OPT_FIRST, BR_OPT_LAST));
			nxt_out.cond_src_first = 5'(ife_field(instr_word,
				COND_SRC1_FIRST, COND_SRC1_LAST));
			nxt_out.cond_src_second = 5'(ife_field(instr_word,
				COND_SRC2_FIRST, COND_SRC2_LAST));
			nxt_out.cond_dest_index = 5'(ife_field(instr_word,
				COND_DEST_FIRST, COND_DEST_LAST));
			nxt_out.cond_field_dest = 3'(ife_field(instr_word,
				FLD_DEST_FIRST, FLD_DEST_LAST));
			nxt_out.cond_field_src = 3'(ife_field(instr_word,
				FLD_SRC_FIRST, FLD_SRC_LAST));
			nxt_out.cond_field_we = is_cond_mask_move ?
				ife_expand(f_cfmask[7:0]) : 32'h0;
			nxt_out.fp_field_we = is_fp_mask_move ?
				ife_expand(f_fpmask[7:0]) : 32'h0;
			nxt_out.fp_src_first = 5'(ife_field(instr_word,
				FP_SRC1_FIRST, FP_SRC1_LAST));
			nxt_out.fp_src_second = 5'(ife_field(instr_word,
				FP_SRC2_FIRST, FP_SRC2_LAST));
			nxt_out.fp_src_third = 5'(ife_field(instr_word,
				FP_SRC3_FIRST, FP_SRC3_LAST));
			nxt_out.fp_dest_index = 5'(ife_field(instr_word,
				FP_DEST_FIRST, FP_DEST_LAST));
			nxt_out.branch_target = ife_narrow(base + disp,
				mode_64bit);
			nxt_out.return_addr = ife_narrow(instr_addr + INSN_BYTES,
				mode_64bit);
			nxt_out.return_addr_we = is_branch &&
				instr_word[31 - SAVE_RETURN_POS];
			nxt_out.ls_disp = ife_narrow(ife_sext({48'h0, f_ls[15:0]},
				LS_DISP_W), mode_64bit);
			nxt_out.word_disp = mode_64bit ?
				ife_sext({48'h0, f_word[13:0], 2'h0},
				WORD_OFF_W + OFF_PAD_W) : 64'h0;
			nxt_out.word_disp_valid = mode_64bit;
			nxt_out.cmp_is_64 = is_compare && mode_64bit &&
				instr_word[31 - CMP_WIDE_POS];
			nxt_out.rot_mask = ife_narrow(mif.mask, mode_64bit);
			nxt_out.ov_we = is_ext_arith &&
				instr_word[31 - OV_ENABLE_POS];
			nxt_out.ov_value = ov_detect;
			nxt_out.so_value = so_after;
			nxt_out.cr_int_we = is_int_record_op &&
				instr_word[31 - RECORD_POS];
			nxt_out.cr_int_bits = {lt, ~lt & ~eq, eq, so_after};
			nxt_out.cr_fp_we = is_fp_record_op &&
				instr_word[31 - RECORD_POS];
			nxt_out.cr_fp_bits = {fp_exc_summary, fp_enabled_summary,
				fp_invalid, fp_overflow};
			nxt_out.seg_reg_select = 4'(ife_field(instr_word,
				SEG_FIRST, SEG_LAST));
			nxt_out.seg_valid = ~mode_64bit;
			nxt_out.spr_select = {f_spr_hi[4:0], f_spr_lo[4:0]};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			valid_ff <= RST_VALID;
			out_ff   <= '0;
		end else begin
			valid_ff <= nxt_valid;
			out_ff   <= nxt_out;
		end
	end

	assign out_valid           = valid_ff;
	assign cond_test_index     = out_ff.cond_test_index;
	assign branch_option_field = out_ff.branch_option_field;
	assign cond_src_first      = out_ff.cond_src_first;
	assign cond_src_second     = out_ff.cond_src_second;
	assign cond_dest_index     = out_ff.cond_dest_index;
	assign cond_field_dest     = out_ff.cond_field_dest;
	assign cond_field_src      = out_ff.cond_field_src;
	assign cond_field_we       = out_ff.cond_field_we;
	assign fp_field_we         = out_ff.fp_field_we;
	assign fp_src_first        = out_ff.fp_src_first;
	assign fp_src_second       = out_ff.fp_src_second;
	assign fp_src_third        = out_ff.fp_src_third;
	assign fp_dest_index       = out_ff.fp_dest_index;
	assign branch_target       = out_ff.branch_target;
	assign return_addr         = out_ff.return_addr;
	assign return_addr_we      = out_ff.return_addr_we;
	assign ls_disp             = out_ff.ls_disp;
	assign word_disp           = out_ff.word_disp;
	assign word_disp_valid     = out_ff.word_disp_valid;
	assign cmp_is_64           = out_ff.cmp_is_64;
	assign rot_mask            = out_ff.rot_mask;
	assign ov_we               = out_ff.ov_we;
	assign ov_value            = out_ff.ov_value;
	assign so_value            = out_ff.so_value;
	assign cr_int_we           = out_ff.cr_int_we;
	assign cr_int_bits         = out_ff.cr_int_bits;
	assign cr_fp_we            = out_ff.cr_fp_we;
	assign cr_fp_bits          = out_ff.cr_fp_bits;
	assign seg_reg_select      = out_ff.seg_reg_select;
	assign seg_valid           = out_ff.seg_valid;
	assign spr_select          = out_ff.spr_select;
endmodule
`default_nettype wire

// ---- design/ife_pkg.sv ----
package ife_pkg;

	localparam int INSN_W  = 32;
	localparam int DATA_W  = 64;
	localparam int HALF_W  = 32;

	// Big-endian bit positions: position 0 is the most significant bit
	localparam int ABS_TARGET_POS     = 30;
	localparam int SAVE_RETURN_POS    = 31;
	localparam int RECORD_POS         = 31;
	localparam int OV_ENABLE_POS      = 21;
	localparam int CMP_WIDE_POS       = 10;

	localparam int COND_OFF_FIRST     = 16;
	localparam int COND_OFF_LAST      = 29;
	localparam int COND_OFF_W         = 14;
	localparam int LONG_OFF_FIRST     = 6;
	localparam int LONG_OFF_LAST      = 29;
	localparam int LONG_OFF_W         = 24;
	localparam int OFF_PAD_W          = 2;
	localparam int COND_TEST_FIRST    = 11;
	localparam int COND_TEST_LAST     = 15;
	localparam int BR_OPT_FIRST       = 6;
	localparam int BR_OPT_LAST        = 10;
	localparam int COND_SRC1_FIRST    = 11;
	localparam int COND_SRC1_LAST     = 15;
	localparam int COND_SRC2_FIRST    = 16;
	localparam int COND_SRC2_LAST     = 20;
	localparam int COND_DEST_FIRST    = 6;
	localparam int COND_DEST_LAST     = 10;
	localparam int FLD_DEST_FIRST     = 6;
	localparam int FLD_DEST_LAST      = 8;
	localparam int FLD_SRC_FIRST      = 11;
	localparam int FLD_SRC_LAST       = 13;
	localparam int CFMASK_FIRST       = 12;
	localparam int CFMASK_LAST        = 19;
	localparam int LS_DISP_FIRST      = 16;
	localparam int LS_DISP_LAST       = 31;
	localparam int LS_DISP_W          = 16;
	localparam int WORD_OFF_FIRST     = 16;
	localparam int WORD_OFF_LAST      = 29;
	localparam int WORD_OFF_W         = 14;
	localparam int FPMASK_FIRST       = 7;
	localparam int FPMASK_LAST        = 14;
	localparam int FP_SRC1_FIRST      = 11;
	localparam int FP_SRC1_LAST       = 15;
	localparam int FP_SRC2_FIRST      = 16;
	localparam int FP_SRC2_LAST       = 20;
	localparam int FP_SRC3_FIRST      = 21;
	localparam int FP_SRC3_LAST       = 25;
	localparam int FP_DEST_FIRST      = 6;
	localparam int FP_DEST_LAST       = 10;
	localparam int MASK_BEGIN_FIRST   = 21;
	localparam int MASK_BEGIN_LAST    = 25;
	localparam int MASK_STOP_FIRST    = 26;
	localparam int MASK_STOP_LAST     = 30;
	localparam int SEG_FIRST          = 12;
	localparam int SEG_LAST           = 15;
	localparam int SPR_LOW_FIRST      = 11;
	localparam int SPR_LOW_LAST       = 15;
	localparam int SPR_HIGH_FIRST     = 16;
	localparam int SPR_HIGH_LAST      = 20;

	localparam logic [6:0]  ROT_MASK_BIAS = 7'h20;
	localparam logic [63:0] INSN_BYTES    = 64'h4;
	localparam logic        RST_VALID     = 1'h0;

	typedef struct packed {
		logic [4:0]  cond_test_index;
		logic [4:0]  branch_option_field;
		logic [4:0]  cond_src_first;
		logic [4:0]  cond_src_second;
		logic [4:0]  cond_dest_index;
		logic [2:0]  cond_field_dest;
		logic [2:0]  cond_field_src;
		logic [31:0] cond_field_we;
		logic [31:0] fp_field_we;
		logic [4:0]  fp_src_first;
		logic [4:0]  fp_src_second;
		logic [4:0]  fp_src_third;
		logic [4:0]  fp_dest_index;
		logic [63:0] branch_target;
		logic [63:0] return_addr;
		logic        return_addr_we;
		logic [63:0] ls_disp;
		logic [63:0] word_disp;
		logic        word_disp_valid;
		logic        cmp_is_64;
		logic [63:0] rot_mask;
		logic        ov_we;
		logic        ov_value;
		logic        so_value;
		logic        cr_int_we;
		logic [3:0]  cr_int_bits;
		logic        cr_fp_we;
		logic [3:0]  cr_fp_bits;
		logic [3:0]  seg_reg_select;
		logic        seg_valid;
		logic [9:0]  spr_select;
	} ife_out_s;

	// Field pulled from big-endian positions first..last, right aligned
	function automatic logic [31:0] ife_field(input logic [31:0] insn,
		input int first, input int last);
		logic [31:0] m;
		m = 32'((64'h1 << (last - first + 1)) - 64'h1);
		return (insn >> (31 - last)) & m;
	endfunction

	// Sign extension of a w-bit value to 64 bits
	function automatic logic [63:0] ife_sext(input logic [63:0] v,
		input int w);
		logic [63:0] m;
		m = (64'h1 << w) - 64'h1;
		return v[w - 1] ? (v | ~m) : (v & m);
	endfunction

	// Machine width cut: 32-bit mode keeps low word, upper half zero
	function automatic logic [63:0] ife_narrow(input logic [63:0] v,
		input logic wide);
		return wide ? v : {32'h0, v[31:0]};
	endfunction

	// Each field mask bit enables four status bits
	function automatic logic [31:0] ife_expand(input logic [7:0] m);
		logic [31:0] r;
		r = 32'h0;
		for (int i = 0; i < 8; i++) begin
			r[4 * i +: 4] = {4{m[i]}};
		end
		return r;
	endfunction

endpackage

// ---- design/ife_mask_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface ife_mask_if;
	logic [4:0]  mask_begin;
	logic [4:0]  mask_stop;
	logic [63:0] mask;
	modport gen  (input mask_begin, input mask_stop, output mask);
	modport user (output mask_begin, output mask_stop, input mask);
endinterface
`default_nettype wire

// ---- design/ife_rot_mask.sv ----
`timescale 1ns/100ps
`default_nettype none
module ife_rot_mask (
	ife_mask_if.gen m
);
	import ife_pkg::*;

	logic [6:0] lo;
	logic [6:0] hi;

	assign lo = {2'h0, m.mask_begin} + ROT_MASK_BIAS;
	assign hi = {2'h0, m.mask_stop} + ROT_MASK_BIAS;

	// Ones from begin+32 to stop+32, wrapping when begin is past stop
	genvar j;
	generate
		for (j = 0; j < 64; j++) begin : g_bit
			localparam logic [6:0] POS = 7'(63 - j);
			assign m.mask[j] = (lo <= hi) ?
				((POS >= lo) && (POS <= hi)) :
				((POS >= lo) || (POS <= hi));
		end
	endgenerate
endmodule
`default_nettype wire

// ---- tb/ife_extractor_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module ife_extractor_sva (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        in_valid,
	input wire logic [31:0] instr_word,
	input wire logic        mode_64bit,
	input wire logic        is_branch,
	input wire logic        is_ext_arith,
	input wire logic        is_compare,
	input wire logic        out_valid,
	input wire logic [4:0]  cond_test_index,
	input wire logic [4:0]  branch_option_field,
	input wire logic [4:0]  fp_src_third,
	input wire logic [63:0] ls_disp,
	input wire logic [63:0] branch_target,
	input wire logic        return_addr_we,
	input wire logic        ov_we,
	input wire logic        cmp_is_64,
	input wire logic [9:0]  spr_select
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_valid_pulse: assert property (1'h1 |=> out_valid == $past(in_valid))
		else $error("out_valid does not follow in_valid");
	a_test_index: assert property (in_valid |=>
		cond_test_index == $past(instr_word[20:16]))
		else $error("tested condition index wrong");
	a_option_field: assert property (in_valid |=>
		branch_option_field == $past(instr_word[25:21]))
		else $error("branch option field wrong");
	a_fp_third: assert property (in_valid |=>
		fp_src_third == $past(instr_word[10:6]))
		else $error("third fp source wrong");
	a_ls_sign: assert property (in_valid && mode_64bit |=>
		ls_disp == {{48{$past(instr_word[15])}}, $past(instr_word[15:0])})
		else $error("load store displacement wrong");
	a_narrow_target: assert property (in_valid && !mode_64bit |=>
		branch_target[63:32] == 32'h0)
		else $error("narrow target upper half not zero");
	a_link_write: assert property (in_valid |=>
		return_addr_we == $past(is_branch && instr_word[0]))
		else $error("return address enable wrong");
	a_excess_enable: assert property (in_valid |=>
		ov_we == $past(is_ext_arith && instr_word[10]))
		else $error("overflow enable wrong");
	a_cmp_wide: assert property (in_valid |=>
		cmp_is_64 == $past(is_compare && mode_64bit && instr_word[21]))
		else $error("compare width wrong");
	a_spr_split: assert property (in_valid |=>
		spr_select == $past({instr_word[15:11], instr_word[20:16]}))
		else $error("special register selector wrong");

	c_link: cover property (out_valid && return_addr_we);
	c_excess: cover property (out_valid && ov_we);
	c_wide: cover property (out_valid && cmp_is_64);
endmodule
bind ife_extractor ife_extractor_sva chk (.*);
`default_nettype wire

// ---- tb/ife_fetch_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ife_fetch_model (
	input  wire logic        clk,
	output var  logic        in_valid,
	output var  logic [31:0] instr_word,
	output var  logic [63:0] instr_addr
);
	initial begin
		in_valid = 1'h0;
		instr_word = 32'h0;
		instr_addr = 64'h0;
	end
	// One word for one cycle, then the idle bus shows garbage
	task automatic issue(input logic [31:0] w, input logic [63:0] a);
		@(posedge clk);
		#1;
		in_valid = 1'h1;
		instr_word = w;
		instr_addr = a;
		@(posedge clk);
		#1;
		in_valid = 1'h0;
		instr_word = ~w;
		instr_addr = ~a;
	endtask
endmodule
`default_nettype wire

// ---- tb/ife_extractor_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module ife_extractor_test;
	logic        clk, resetn, in_valid, mode_64bit, is_branch;
	logic        use_long_offset, is_ext_arith, is_int_record_op;
	logic        is_fp_record_op, is_cond_mask_move, is_fp_mask_move;
	logic        is_compare, ov_detect, so_current, fp_exc_summary;
	logic        fp_enabled_summary, fp_invalid, fp_overflow, out_valid;
	logic        return_addr_we, word_disp_valid, cmp_is_64, ov_we;
	logic        ov_value, so_value, cr_int_we, cr_fp_we, seg_valid;
	logic [2:0]  cond_field_dest, cond_field_src;
	logic [3:0]  cr_int_bits, cr_fp_bits, seg_reg_select;
	logic [4:0]  cond_test_index, branch_option_field, cond_src_first;
	logic [4:0]  cond_src_second, cond_dest_index, fp_src_first;
	logic [4:0]  fp_src_second, fp_src_third, fp_dest_index;
	logic [9:0]  spr_select;
	logic [31:0] instr_word, cond_field_we, fp_field_we;
	logic [63:0] instr_addr, int_result, branch_target, return_addr;
	logic [63:0] ls_disp, word_disp, rot_mask;
	int          failures, n_checks;

	ife_fetch_model fm (.*);
	ife_extractor   dut (.*);

	function automatic logic [63:0] sx(input logic [63:0] v, input int w);
		return v[w-1] ? v | ~((64'h1 << w) - 64'h1) : v;
	endfunction
	function automatic logic [63:0] nw(input logic [63:0] v);
		return mode_64bit ? v : {32'h0, v[31:0]};
	endfunction
	function automatic logic [31:0] ex(input logic [7:0] m);
		logic [31:0] r;
		for (int i = 0; i < 8; i++) r[31-4*i -: 4] = {4{m[7-i]}};
		return r;
	endfunction

	task automatic chk(input string nm, input logic [63:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic go(input logic [31:0] w, input logic [63:0] a);
		fm.issue(w, a);
		chk("out_valid", out_valid, 64'h1);
	endtask

	task automatic t_branch();
		logic [31:0] w;
		logic [63:0] a;
		a = 64'h1000_0000_0000_0100;
		w = {6'h10, 5'h0c, 5'h13, 14'h3ff8, 2'h1};
		mode_64bit = 1'h1;
		is_branch = 1'h1;
		go(w, a);
		chk("target", branch_target, a + sx({w[15:2], 2'h0}, 16));
		chk("ret_we", return_addr_we, 64'h1);
		chk("ret", return_addr, a + 64'h4);
		chk("test_index", cond_test_index, w[20:16]);
		chk("option", branch_option_field, w[25:21]);
		w = {6'h12, 24'h800001, 2'h2};
		mode_64bit = 1'h0;
		use_long_offset = 1'h1;
		go(w, a);
		chk("target", branch_target, nw(sx({w[25:2], 2'h0}, 26)));
		chk("ret_we", return_addr_we, 64'h0);
		chk("ret", return_addr, nw(a + 64'h4));
		use_long_offset = 1'h0;
		$display("branch test done");
	endtask

	task automatic t_fields();
		logic [31:0] w;
		w = 32'h7d4a_5a96;
		mode_64bit = 1'h1;
		is_cond_mask_move = 1'h1;
		go(w, 64'h0);
		chk("src1", cond_src_first, w[20:16]);
		chk("src2", cond_src_second, w[15:11]);
		chk("dest", cond_dest_index, w[25:21]);
		chk("fld_dest", cond_field_dest, w[25:23]);
		chk("fld_src", cond_field_src, w[20:18]);
		chk("cond_we", cond_field_we, ex(w[19:12]));
		chk("fp_we", fp_field_we, 64'h0);
		is_cond_mask_move = 1'h0;
		is_fp_mask_move = 1'h1;
		go(w, 64'h0);
		chk("cond_we", cond_field_we, 64'h0);
		chk("fp_we", fp_field_we, ex(w[24:17]));
		is_fp_mask_move = 1'h0;
		$display("field test done");
	endtask

	task automatic t_ls();
		logic [31:0] w;
		w = 32'hc1e3_8ffe;
		is_compare = 1'h1;
		for (int m = 0; m < 2; m++) begin
			mode_64bit = m[0];
			go(w, 64'h0);
			chk("ls_disp", ls_disp, nw(sx(w[15:0], 16)));
			chk("word", word_disp, m ? sx({w[15:2], 2'h0}, 16) : 0);
			chk("word_valid", word_disp_valid, m[0]);
			chk("cmp64", cmp_is_64, m & w[21]);
			chk("seg", seg_reg_select, w[19:16]);
			chk("seg_valid", seg_valid, !m);
			chk("spr", spr_select, {w[15:11], w[20:16]});
			chk("fp_a", fp_src_first, w[20:16]);
			chk("fp_b", fp_src_second, w[15:11]);
			chk("fp_c", fp_src_third, w[10:6]);
			chk("fp_d", fp_dest_index, w[25:21]);
		end
		is_compare = 1'h0;
		$display("displacement test done");
	endtask

	task automatic t_rot();
		logic [10:0] cs [4] = '{11'h46a, 11'h685, 11'h01f, 11'h3ff};
		logic [63:0] e;
		logic [4:0]  b, s;
		for (int k = 0; k < 4; k++) begin
			{mode_64bit, b, s} = cs[k];
			for (int q = 0; q < 64; q++) begin
				e[63-q] = (b <= s) ? (q >= b + 32 && q <= s + 32)
					: (q >= b + 32 || q <= s + 32);
			end
			go({21'h0a5a5, b, s, 1'h0}, 64'h0);
			chk("rot_mask", rot_mask, nw(e));
		end
		$display("rotate test done");
	endtask

	task automatic t_rec();
		mode_64bit = 1'h1;
		{is_ext_arith, is_int_record_op, is_fp_record_op} = 3'h7;
		int_result = 64'hffff_ffff_ffff_fff0;
		ov_detect = 1'h1;
		{fp_exc_summary, fp_enabled_summary, fp_invalid, fp_overflow} = 4'hb;
		go(32'h7c00_0601, 64'h0);
		chk("excess_we", ov_we, 64'h1);
		chk("so", so_value, 64'h1);
		chk("excess_val", ov_value, 64'h1);
		chk("rec_int_we", cr_int_we, 64'h1);
		chk("rec_int", cr_int_bits, 64'h9);
		chk("rec_fp_we", cr_fp_we, 64'h1);
		chk("rec_fp", cr_fp_bits, 64'hb);
		int_result = 64'h0;
		go(32'h7c00_0201, 64'h0);
		chk("excess_we", ov_we, 64'h0);
		chk("so", so_value, 64'h0);
		chk("rec_int", cr_int_bits, 64'h2);
		go(32'h7c00_0200, 64'h0);
		chk("rec_int_we", cr_int_we, 64'h0);
		{is_ext_arith, is_int_record_op, is_fp_record_op} = 3'h0;
		$display("record test done");
	endtask

	task automatic t_reset();
		resetn = 1'h0;
		#1;
		chk("rst_valid", out_valid, 64'h0);
		chk("rst_target", branch_target, 64'h0);
		chk("rst_fp", cr_fp_bits, 64'h0);
		@(posedge clk);
		#1;
		resetn = 1'h1;
		@(posedge clk);
		#1;
		chk("rst_hold", branch_target, 64'h0);
		chk("rst_idle", out_valid, 64'h0);
		$display("reset test done");
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		#20000;
		failures++;
		give_verdict();
	end
	initial begin
		failures = 0;
		n_checks = 0;
		resetn = 1'h0;
		{mode_64bit, is_branch, use_long_offset, is_ext_arith} = 4'h0;
		{is_int_record_op, is_fp_record_op, is_compare} = 3'h0;
		{is_cond_mask_move, is_fp_mask_move, ov_detect, so_current} = 4'h0;
		{fp_exc_summary, fp_enabled_summary, fp_invalid, fp_overflow} = 4'h0;
		int_result = 64'h0;
		repeat (4) @(posedge clk);
		#1;
		resetn = 1'h1;
		chk("idle", out_valid, 64'h0);
		t_branch();
		t_fields();
		t_ls();
		t_rot();
		t_rec();
		t_reset();
		give_verdict();
	end
endmodule
`default_nettype wire
